// ---- aao_alu.sv ----
`timescale 1ns/10ps
module aao_alu
	import aao_pkg::*;
(
	input  wire logic [DATA_W-1:0] x,
	input  wire logic [DATA_W-1:0] y,
	input  wire logic              cin,
	input  wire aao_op_e           op,
	output logic [DATA_W-1:0]      res,
	output logic [FLAG_W-1:0]      fl
);

	logic [DATA_W:0] sum;
	logic [DATA_W:0] dif;
	logic [NIB:0]    nsum;
	logic [NIB:0]    ndif;
	logic            sub;

	always_comb begin
		sub  = (op == OP_SUB) || (op == OP_SUBR) || (op == OP_SUBC);
		sum  = {1'b0, x} + {1'b0, y} + {{DATA_W{1'b0}}, cin};
		dif  = {1'b0, x} - {1'b0, y} - {{DATA_W{1'b0}}, cin};
		nsum = {1'b0, x[NIB-1:0]} + {1'b0, y[NIB-1:0]} + {{NIB{1'b0}}, cin};
		ndif = {1'b0, x[NIB-1:0]} - {1'b0, y[NIB-1:0]} - {{NIB{1'b0}}, cin};
		res  = sub ? dif[DATA_W-1:0] : sum[DATA_W-1:0];
		fl   = FM_NONE;
		// Borrow out of the top bit doubles as carry for subtraction
		fl[FLAG_C]  = sub ? dif[DATA_W] : sum[DATA_W];
		fl[FLAG_HC] = sub ? ndif[NIB] : nsum[NIB];
		fl[FLAG_VF] = sub ? ((x[MSB] != y[MSB]) && (res[MSB] != x[MSB]))
			: ((x[MSB] == y[MSB]) && (res[MSB] != x[MSB]));
		case (op)
			OP_AND:  res = x & y;
			OP_OR:   res = x | y;
			OP_XOR:  res = x ^ y;
			default: res = res;
		endcase
		fl[FLAG_Z] = (res == '0);
	end

endmodule // aao_alu

// ---- aao_exec_unit.sv ----
// Summary of operation
// - Indirect store writes accumulator to address held in a pointer byte; flags kept.
// - Exchange swaps accumulator and memory byte; flags kept.
// - Push stores accumulator and flags pair at stack pointer, then adds two.
// - Pop subtracts two from stack pointer, then loads accumulator and flags.
// - Add immediate sums into accumulator, updating zero, carry, half carry, overflow.
// - Add memory sums into accumulator or memory, updating all four flags.
// - Add with carry memory forms add accumulator, memory and carry.
// - Single operand add with carry adds carry to accumulator or memory.
// - Subtract immediate or memory from accumulator, all four flags updated.
// - Memory destination subtract stores memory minus accumulator back to memory.
// - Subtract with borrow gives accumulator minus memory minus carry.
// - Zero fill right shift moves bits down, old bit 0 to carry only.
// - Right rotate through carry puts old carry in bit 7.
// - Zero fill left shift moves bits up, old bit 7 to carry only.
// - Left rotate through carry puts old carry in bit 0.
// - Nibble swap exchanges accumulator halves, flags untouched.
// - AND with immediate or memory, result to accumulator or memory, zero only.
// - OR with immediate or memory, result to accumulator or memory, zero only.
// - XOR with immediate or memory, result to accumulator or memory, zero only.
// - XOR may target an I/O register, written back to that register.
// - Complement inverts accumulator or memory byte in place.
// - Negate replaces accumulator with inverted value plus one.
// - Zero flag set when affecting result is zero, else cleared.
// - Half carry set on carry out of the low nibble for add, borrow out of it for subtract.
// - Carry flag is unsigned carry for add, borrow for subtract.
// - Overflow set when signed result leaves the byte range.
`timescale 1ns/10ps
module aao_exec_unit
	import aao_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              nrst,
	input  wire logic              cmd_valid,
	output logic                   cmd_ready,
	input  wire aao_op_e           cmd_op,
	input  wire logic              cmd_src_mem,
	input  wire logic              cmd_to_mem,
	input  wire logic              cmd_io,
	input  wire logic [DATA_W-1:0] cmd_addr,
	input  wire logic [DATA_W-1:0] cmd_imm,
	output logic                   done,
	output logic [DATA_W-1:0]      mem_addr,
	output logic [DATA_W-1:0]      mem_wdata,
	output logic                   mem_we,
	output logic                   mem_re,
	output logic                   mem_io,
	input  wire logic [DATA_W-1:0] mem_rdata,
	input  wire logic [REG_AW-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [DATA_W-1:0]      reg_rdata
);

	typedef enum logic [2:0] {
		S_IDLE,
		S_WAIT,
		S_EXEC,
		S_PUSH2,
		S_POP2,
		S_POP3
	} aao_state_e;

	aao_state_e          state;
	aao_op_e             op_q;
	logic                to_mem_q;
	logic                use_mem_q;
	logic [DATA_W-1:0]   imm_q;
	logic [DATA_W-1:0]   acc;
	logic [FLAG_W-1:0]   flags;
	logic [DATA_W-1:0]   stack_top_pointer;
	logic                accept;
	logic                need_read;
	logic                exec;
	logic                sw_wr;
	logic [DATA_W-1:0]   opnd;
	logic [DATA_W-1:0]   alu_x;
	logic [DATA_W-1:0]   alu_y;
	logic                alu_cin;
	logic [DATA_W-1:0]   alu_res;
	logic [FLAG_W-1:0]   alu_fl;
	logic [DATA_W-1:0]   sh_v;
	logic [DATA_W-1:0]   sh_res;
	logic                sh_cout;
	logic [DATA_W-1:0]   res;
	logic [FLAG_W-1:0]   res_fl;
	logic [FLAG_W-1:0]   fmask;
	logic [FLAG_W-1:0]   next_flags;

	assign cmd_ready = (state == S_IDLE);
	assign accept    = cmd_ready && cmd_valid;
	assign exec      = (state == S_EXEC);
	// Software writes are held off while an operation owns the registers
	assign sw_wr     = reg_wr && cmd_ready;
	assign need_read = cmd_src_mem || cmd_to_mem || (cmd_op == OP_IDX_ST)
		|| (cmd_op == OP_XCH) || (cmd_op == OP_POPAF);
	// Memory data is valid in the cycle after the read strobe, i.e. in S_EXEC
	assign opnd      = use_mem_q ? mem_rdata : imm_q;

	// Operand routing into the adder
	always_comb begin
		alu_x   = acc;
		alu_y   = opnd;
		alu_cin = 1'b0;
		case (op_q)
			OP_SUBR: begin
				alu_x = opnd;
				alu_y = acc;
			end
			OP_ADDC1: begin
				alu_x   = to_mem_q ? opnd : acc;
				alu_y   = '0;
				alu_cin = flags[FLAG_C];
			end
			OP_ADDC, OP_SUBC: alu_cin = flags[FLAG_C];
			default: alu_cin = 1'b0;
		endcase
	end

	assign sh_v = to_mem_q ? opnd : acc;

	aao_alu u_alu (
		.x   (alu_x),
		.y   (alu_y),
		.cin (alu_cin),
		.op  (op_q),
		.res (alu_res),
		.fl  (alu_fl)
	);

	aao_shift u_shift (
		.v    (sh_v),
		.cin  (flags[FLAG_C]),
		.op   (op_q),
		.res  (sh_res),
		.cout (sh_cout)
	);

	// Untouched flags pass through the mask unchanged
	always_comb begin
		res        = aao_is_unary(op_q) ? sh_res : alu_res;
		res_fl     = alu_fl;
		res_fl[FLAG_Z] = (res == '0);
		if (aao_is_unary(op_q))
			res_fl[FLAG_C] = sh_cout;
		fmask      = aao_flag_mask(op_q);
		next_flags = (flags & ~fmask) | (res_fl & fmask);
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state <= S_IDLE;
		end else begin
			case (state)
				S_IDLE:  if (cmd_valid) state <= need_read ? S_WAIT : S_EXEC;
				S_WAIT:  state <= S_EXEC;
				S_EXEC: begin
					if (op_q == OP_PUSHAF)
						state <= S_PUSH2;
					else if (op_q == OP_POPAF)
						state <= S_POP2;
					else
						state <= S_IDLE;
				end
				S_PUSH2: state <= S_IDLE;
				S_POP2:  state <= S_POP3;
				S_POP3:  state <= S_IDLE;
				default: state <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			op_q      <= OP_ADD;
			to_mem_q  <= 1'b0;
			use_mem_q <= 1'b0;
			imm_q     <= '0;
		end else if (accept) begin
			op_q      <= cmd_op;
			to_mem_q  <= cmd_to_mem;
			use_mem_q <= need_read;
			imm_q     <= cmd_imm;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			acc <= ACC_RESET;
		end else if (exec) begin
			case (op_q)
				OP_IDX_ST, OP_PUSHAF: acc <= acc;
				OP_XCH:   acc <= opnd;
				OP_POPAF: acc <= mem_rdata;
				default:  if (!to_mem_q) acc <= res;
			endcase
		end else if (sw_wr && reg_addr == REG_ACC) begin
			acc <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			flags <= FLAG_RESET;
		end else if (exec) begin
			flags <= next_flags;
		end else if (state == S_POP3) begin
			flags <= mem_rdata[FLAG_W-1:0];
		end else if (sw_wr && reg_addr == REG_FLAG) begin
			flags <= reg_wdata[FLAG_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			stack_top_pointer <= STACK_RESET;
		end else if (accept && cmd_op == OP_POPAF) begin
			stack_top_pointer <= stack_top_pointer - STACK_STEP;
		end else if (state == S_PUSH2) begin
			stack_top_pointer <= stack_top_pointer + STACK_STEP;
		end else if (sw_wr && reg_addr == REG_STACK) begin
			stack_top_pointer <= reg_wdata;
		end
	end

	// Memory and I/O port: every output is a flop, strobes last one cycle
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			mem_addr  <= '0;
			mem_wdata <= '0;
			mem_we    <= 1'b0;
			mem_re    <= 1'b0;
			mem_io    <= 1'b0;
		end else begin
			mem_we <= 1'b0;
			mem_re <= 1'b0;
			if (accept) begin
				mem_re   <= need_read;
				mem_io   <= cmd_io;
				mem_addr <= (cmd_op == OP_POPAF)
					? stack_top_pointer - STACK_STEP : cmd_addr;
			end else if (exec) begin
				case (op_q)
					OP_IDX_ST: begin
						mem_we    <= 1'b1;
						mem_io    <= 1'b0;
						mem_addr  <= opnd;
						mem_wdata <= acc;
					end
					OP_XCH: begin
						mem_we    <= 1'b1;
						mem_wdata <= acc;
					end
					OP_PUSHAF: begin
						mem_we    <= 1'b1;
						mem_io    <= 1'b0;
						mem_addr  <= stack_top_pointer;
						mem_wdata <= acc;
					end
					OP_POPAF: begin
						mem_re   <= 1'b1;
						mem_addr <= stack_top_pointer + STACK_HI_OFS;
					end
					default: begin
						if (to_mem_q) begin
							mem_we    <= 1'b1;
							mem_wdata <= res;
						end
					end
				endcase
			end else if (state == S_PUSH2) begin
				mem_we    <= 1'b1;
				mem_addr  <= stack_top_pointer + STACK_HI_OFS;
				mem_wdata <= {{(DATA_W-FLAG_W){1'b0}}, flags};
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			done <= 1'b0;
		end else begin
			done <= (exec && op_q != OP_PUSHAF && op_q != OP_POPAF)
				|| (state == S_PUSH2) || (state == S_POP3);
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_ACC:    reg_rdata <= acc;
				REG_FLAG:   reg_rdata <= {{(DATA_W-FLAG_W){1'b0}}, flags};
				REG_STACK:  reg_rdata <= stack_top_pointer;
				REG_STATUS: reg_rdata <= {{(DATA_W-1){1'b0}}, ~cmd_ready};
				default:    reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	a_idx_store: assert property (@(posedge core_clk) disable iff (!nrst)
		exec && op_q == OP_IDX_ST |=> mem_we && mem_addr == $past(opnd)
			&& mem_wdata == $past(acc) && flags == $past(flags))
		else $error("indirect store address, data or flags wrong");

	a_xch_swap: assert property (@(posedge core_clk) disable iff (!nrst)
		exec && op_q == OP_XCH |=> acc == $past(opnd)
			&& mem_wdata == $past(acc) && mem_we && flags == $past(flags))
		else $error("exchange did not swap both ways");

	a_push_step: assert property (@(posedge core_clk) disable iff (!nrst)
		exec && op_q == OP_PUSHAF |-> ##2 (mem_we
			&& stack_top_pointer
				== 8'($past(stack_top_pointer, 2) + STACK_STEP)
			&& mem_addr
				== 8'($past(stack_top_pointer, 2) + STACK_HI_OFS)))
		else $error("push did not write pair and advance pointer");

	a_pop_first: assert property (@(posedge core_clk) disable iff (!nrst)
		accept && cmd_op == OP_POPAF |=>
			stack_top_pointer == 8'($past(stack_top_pointer) - STACK_STEP)
			&& mem_re && mem_addr == stack_top_pointer)
		else $error("pop did not lower pointer before reading");

	a_add_acc: assert property (@(posedge core_clk) disable iff (!nrst)
		exec && op_q == OP_ADD && !to_mem_q
			|=> acc == 8'($past(acc) + $past(opnd)))
		else $error("add result wrong");

	a_sub_borrow: assert property (@(posedge core_clk) disable iff (!nrst)
		exec && op_q == OP_SUB |=> flags[FLAG_C] == ($past(acc) < $past(opnd)))
		else $error("subtract borrow wrong");

	a_shift_carry: assert property (@(posedge core_clk) disable iff (!nrst)
		exec && op_q == OP_SHR |=> flags[FLAG_C] == $past(sh_v[0])
			&& (flags & ~FM_C) == ($past(flags) & ~FM_C))
		else $error("right shift carry or other flags wrong");

	a_swap_nibble: assert property (@(posedge core_clk) disable iff (!nrst)
		exec && op_q == OP_SWAP && !to_mem_q |=> acc[NIB-1:0] == $past(acc[MSB:NIB])
			&& acc[MSB:NIB] == $past(acc[NIB-1:0]) && flags == $past(flags))
		else $error("nibble swap wrong");

	a_logic_zero: assert property (@(posedge core_clk) disable iff (!nrst)
		exec && (op_q == OP_AND || op_q == OP_OR || op_q == OP_XOR)
			|=> flags[FLAG_Z] == ((to_mem_q ? mem_wdata : acc) == '0)
			&& (flags & ~FM_Z) == ($past(flags) & ~FM_Z))
		else $error("logic zero flag wrong or other flag moved");

endmodule // aao_exec_unit

// ---- aao_mem_model.sv ----
`timescale 1ns/10ps
module aao_mem_model
	import aao_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic [DATA_W-1:0] mem_addr,
	input  wire logic [DATA_W-1:0] mem_wdata,
	input  wire logic              mem_we,
	input  wire logic              mem_re,
	input  wire logic              mem_io,
	output logic      [DATA_W-1:0] mem_rdata
);
	logic [DATA_W-1:0] ram [256];
	logic [DATA_W-1:0] io  [256];

	initial mem_rdata = 8'h00;

	// Outside the read slot the bus toggles, so a late sample cannot
	// pass by reusing stale data
	always @(posedge core_clk) begin
		if (mem_re)
			mem_rdata <= mem_io ? io[mem_addr] : ram[mem_addr];
		else
			mem_rdata <= ~mem_rdata;
		if (mem_we && mem_io)
			io[mem_addr] <= mem_wdata;
		else if (mem_we)
			ram[mem_addr] <= mem_wdata;
	end
endmodule // aao_mem_model

// ---- aao_pkg.sv ----
package aao_pkg;

	localparam int DATA_W = 8;
	localparam int MSB    = DATA_W - 1;
	localparam int NIB    = 4;
	localparam int FLAG_W = 4;

	// Flag register bit positions
	localparam int FLAG_Z  = 0;
	localparam int FLAG_C  = 1;
	localparam int FLAG_HC = 2;
	localparam int FLAG_VF = 3;

	// Flag update masks
	localparam logic [FLAG_W-1:0] FM_NONE  = 4'h0;
	localparam logic [FLAG_W-1:0] FM_Z     = 4'h1;
	localparam logic [FLAG_W-1:0] FM_C     = 4'h2;
	localparam logic [FLAG_W-1:0] FM_ARITH = 4'hf;

	// Register port map
	localparam int              REG_AW     = 4;
	localparam logic [REG_AW-1:0] REG_ACC    = 4'h0;
	localparam logic [REG_AW-1:0] REG_FLAG   = 4'h1;
	localparam logic [REG_AW-1:0] REG_STACK  = 4'h2;
	localparam logic [REG_AW-1:0] REG_STATUS = 4'h3;

	localparam logic [DATA_W-1:0] ACC_RESET    = 8'h00;
	localparam logic [DATA_W-1:0] STACK_RESET  = 8'h00;
	localparam logic [FLAG_W-1:0] FLAG_RESET   = 4'h0;
	localparam logic [DATA_W-1:0] STACK_STEP   = 8'h02;
	localparam logic [DATA_W-1:0] STACK_HI_OFS = 8'h01;
	localparam logic [DATA_W-1:0] NEG_ONE      = 8'h01;

	typedef enum logic [4:0] {
		OP_IDX_ST,
		OP_XCH,
		OP_PUSHAF,
		OP_POPAF,
		OP_ADD,
		OP_ADDC,
		OP_ADDC1,
		OP_SUB,
		OP_SUBR,
		OP_SUBC,
		OP_SHR,
		OP_SRC,
		OP_SHL,
		OP_SLC,
		OP_SWAP,
		OP_AND,
		OP_OR,
		OP_XOR,
		OP_NOT,
		OP_NEG
	} aao_op_e;

	function automatic logic [FLAG_W-1:0] aao_flag_mask(aao_op_e op);
		case (op)
			OP_ADD, OP_ADDC, OP_ADDC1,
			OP_SUB, OP_SUBR, OP_SUBC:   return FM_ARITH;
			OP_SHR, OP_SRC, OP_SHL, OP_SLC: return FM_C;
			OP_AND, OP_OR, OP_XOR, OP_NEG: return FM_Z;
			default:                     return FM_NONE;
		endcase
	endfunction

	function automatic logic aao_is_unary(aao_op_e op);
		case (op)
			OP_SHR, OP_SRC, OP_SHL, OP_SLC,
			OP_SWAP, OP_NOT, OP_NEG: return 1'b1;
			default:                 return 1'b0;
		endcase
	endfunction

endpackage

// ---- aao_shift.sv ----
`timescale 1ns/10ps
module aao_shift
	import aao_pkg::*;
(
	input  wire logic [DATA_W-1:0] v,
	input  wire logic              cin,
	input  wire aao_op_e           op,
	output logic [DATA_W-1:0]      res,
	output logic                   cout
);

	always_comb begin
		res  = v;
		cout = cin;
		case (op)
			OP_SHR: begin
				res  = {1'b0, v[MSB:1]};
				cout = v[0];
			end
			OP_SRC: begin
				res  = {cin, v[MSB:1]};
				cout = v[0];
			end
			OP_SHL: begin
				res  = {v[MSB-1:0], 1'b0};
				cout = v[MSB];
			end
			OP_SLC: begin
				res  = {v[MSB-1:0], cin};
				cout = v[MSB];
			end
			OP_SWAP: res = {v[NIB-1:0], v[MSB:NIB]};
			OP_NOT:  res = ~v;
			OP_NEG:  res = (~v) + NEG_ONE;
			default: res = v;
		endcase
	end

endmodule // aao_shift

// ---- test_accumulator_alu_ops.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("wrong value %s expected %h seen %h", n, e, g); \
	end \
end
module test_accumulator_alu_ops
	import aao_pkg::*;
;
	localparam logic [7:0] ADR = 8'h20;

	logic              core_clk  = 1'b0;
	logic              nrst      = 1'b0;
	logic              cmd_valid = 1'b0;
	logic              cmd_ready;
	aao_op_e           cmd_op    = OP_ADD;
	logic              cmd_src_mem = 1'b0;
	logic              cmd_to_mem  = 1'b0;
	logic              cmd_io    = 1'b0;
	logic [DATA_W-1:0] cmd_addr  = 8'h00;
	logic [DATA_W-1:0] cmd_imm   = 8'h00;
	logic              done;
	logic [DATA_W-1:0] mem_addr;
	logic [DATA_W-1:0] mem_wdata;
	logic              mem_we;
	logic              mem_re;
	logic              mem_io;
	logic [DATA_W-1:0] mem_rdata;
	logic [REG_AW-1:0] reg_addr  = 4'h0;
	logic [DATA_W-1:0] reg_wdata = 8'h00;
	logic              reg_wr    = 1'b0;
	logic              reg_rd    = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	int                fail_count = 0;
	int                cmp_count  = 0;
	aao_op_e           sh [4] = '{OP_SHR, OP_SRC, OP_SHL, OP_SLC};
	aao_op_e           lg [3] = '{OP_AND, OP_OR, OP_XOR};
	logic [2:0]        md [3] = '{3'h0, 3'h1, 3'h3};

	aao_exec_unit u_aao_exec_unit (
		.core_clk, .nrst, .cmd_valid, .cmd_ready, .cmd_op,
		.cmd_src_mem, .cmd_to_mem, .cmd_io, .cmd_addr, .cmd_imm,
		.done, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_io,
		.mem_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata
	);

	aao_mem_model u_aao_mem_model (
		.core_clk, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_io,
		.mem_rdata
	);

	always #12.5 core_clk = ~core_clk;

	function automatic logic [11:0] ar(input logic [7:0] a, b,
		input logic ci, sb);
		logic [8:0] r;
		logic       h;
		logic       v;
		if (sb) begin
			r = {1'b0, a} - {1'b0, b} - 9'(ci);
			h = {1'b0, a[3:0]} < ({1'b0, b[3:0]} + 5'(ci));
			v = (a[7] != b[7]) && (r[7] != a[7]);
		end else begin
			r = {1'b0, a} + {1'b0, b} + 9'(ci);
			h = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci)) > 5'h0f;
			v = (a[7] == b[7]) && (r[7] != a[7]);
		end
		return {v, h, r[8], r[7:0] == 8'h00, r[7:0]};
	endfunction

	function automatic logic [11:0] lz(input logic [3:0] f,
		input logic [7:0] r);
		return {f[3:1], r == 8'h00, r};
	endfunction

	// Reference result {flags, value}; b is the target for one-operand ops
	function automatic logic [11:0] rf(input aao_op_e op,
		input logic [7:0] a, b, input logic [3:0] f);
		logic c;
		c = f[FLAG_C];
		case (op)
			OP_ADD:   return ar(a, b, 1'b0, 1'b0);
			OP_ADDC:  return ar(a, b, c, 1'b0);
			OP_ADDC1: return ar(b, 8'h00, c, 1'b0);
			OP_SUB:   return ar(a, b, 1'b0, 1'b1);
			OP_SUBR:  return ar(b, a, 1'b0, 1'b1);
			OP_SUBC:  return ar(a, b, c, 1'b1);
			OP_SHR:   return {f[3:2], b[0], f[0], 1'b0, b[7:1]};
			OP_SRC:   return {f[3:2], b[0], f[0], c, b[7:1]};
			OP_SHL:   return {f[3:2], b[7], f[0], b[6:0], 1'b0};
			OP_SLC:   return {f[3:2], b[7], f[0], b[6:0], c};
			OP_SWAP:  return {f, b[3:0], b[7:4]};
			OP_AND:   return lz(f, a & b);
			OP_OR:    return lz(f, a | b);
			OP_XOR:   return lz(f, a ^ b);
			OP_NOT:   return {f, ~b};
			OP_NEG:   return lz(f, ~b + 8'h01);
			default:  return {f, a};
		endcase
	endfunction

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic cr(input string n, input logic [3:0] a,
		input logic [7:0] x);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(n, x, reg_rdata)
	endtask

	task automatic setup(input logic [7:0] a, input logic [3:0] f);
		reg_write(REG_ACC, a);
		reg_write(REG_FLAG, {4'h0, f});
	endtask

	task automatic run(input aao_op_e op, input logic [2:0] m,
		input logic [7:0] ad, im);
		int n;
		@(posedge core_clk);
		cmd_valid   <= 1'b1;
		cmd_op      <= op;
		cmd_src_mem <= m[0];
		cmd_to_mem  <= m[1];
		cmd_io      <= m[2];
		cmd_addr    <= ad;
		cmd_imm     <= im;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		n = 0;
		#1;
		`CHK("busy", 1'b0, cmd_ready)
		while (done !== 1'b1 && n < 12) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		`CHK("done", 1'b1, done)
		`CHK("ready", 1'b1, cmd_ready)
	endtask

	// Mode bits: 0 operand from memory, 1 result to memory, 2 I/O space
	task automatic t(input aao_op_e op, input logic [2:0] m,
		input logic [7:0] a, v, input logic [3:0] f);
		logic [11:0] e;
		logic        un;
		un = op inside {OP_ADDC1, OP_SHR, OP_SRC, OP_SHL, OP_SLC,
			OP_SWAP, OP_NOT, OP_NEG};
		e = rf(op, a, (un && !m[1]) ? a : v, f);
		setup(a, f);
		if (m[2])
			u_aao_mem_model.io[ADR] = v;
		else
			u_aao_mem_model.ram[ADR] = v;
		run(op, m, ADR, v);
		cr("acc", REG_ACC, m[1] ? a : e[7:0]);
		cr("flags", REG_FLAG, {4'h0, e[11:8]});
		if (m[1])
			`CHK("mem", e[7:0], m[2] ? u_aao_mem_model.io[ADR] :
				u_aao_mem_model.ram[ADR])
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		results();
	end

	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 4; i++)
			cr("reset", 4'(i), 8'h00);
		reg_write(4'hf, 8'hff);
		cr("unmapped", 4'hf, 8'h00);
		t(OP_ADD, 3'h0, 8'h0f, 8'h01, 4'h0);
		t(OP_ADD, 3'h0, 8'h7f, 8'h01, 4'h0);
		t(OP_ADD, 3'h0, 8'hff, 8'h01, 4'h0);
		t(OP_ADD, 3'h1, 8'h12, 8'h34, 4'hf);
		t(OP_ADD, 3'h3, 8'h90, 8'h90, 4'h0);
		t(OP_ADDC, 3'h1, 8'h10, 8'h0f, 4'h2);
		t(OP_ADDC, 3'h3, 8'h80, 8'h7f, 4'h2);
		t(OP_ADDC1, 3'h0, 8'hff, 8'h00, 4'h2);
		t(OP_ADDC1, 3'h3, 8'h55, 8'h7f, 4'h2);
		t(OP_SUB, 3'h0, 8'h00, 8'h01, 4'h0);
		t(OP_SUB, 3'h1, 8'h80, 8'h01, 4'h0);
		t(OP_SUBR, 3'h3, 8'h05, 8'h03, 4'h0);
		t(OP_SUBC, 3'h1, 8'h10, 8'h0f, 4'h2);
		t(OP_SUBC, 3'h1, 8'h20, 8'h05, 4'h0);
		foreach (sh[i]) begin
			t(sh[i], 3'h0, 8'h81, 8'h00, 4'hd);
			t(sh[i], 3'h3, 8'h00, 8'h7e, 4'h2);
		end
		t(OP_SWAP, 3'h0, 8'h3c, 8'h00, 4'ha);
		foreach (lg[i])
			foreach (md[j])
				t(lg[i], md[j], 8'hf0, 8'h0f, 4'he);
		t(OP_OR, 3'h1, 8'h01, 8'h00, 4'h1);
		t(OP_XOR, 3'h7, 8'h3c, 8'h5a, 4'h6);
		t(OP_NOT, 3'h0, 8'h96, 8'h00, 4'h5);
		t(OP_NOT, 3'h3, 8'h00, 8'hff, 4'ha);
		t(OP_NEG, 3'h0, 8'h01, 8'h00, 4'hc);
		t(OP_NEG, 3'h0, 8'h00, 8'h00, 4'h6);
		setup(8'ha5, 4'h5);
		u_aao_mem_model.ram[ADR] = 8'h5b;
		u_aao_mem_model.ram[8'h5b] = 8'h00;
		run(OP_IDX_ST, 3'h3, ADR, 8'h00);
		cr("flags", REG_FLAG, 8'h05);
		`CHK("idx", 8'ha5, u_aao_mem_model.ram[8'h5b])
		setup(8'h11, 4'ha);
		u_aao_mem_model.ram[ADR] = 8'h22;
		run(OP_XCH, 3'h3, ADR, 8'h00);
		cr("acc", REG_ACC, 8'h22);
		`CHK("xch", 8'h11, u_aao_mem_model.ram[ADR])
		cr("flags", REG_FLAG, 8'h0a);
		setup(8'h3c, 4'h9);
		reg_write(REG_STACK, 8'h40);
		run(OP_PUSHAF, 3'h0, ADR, 8'h00);
		cr("stack", REG_STACK, 8'h42);
		cr("flags", REG_FLAG, 8'h09);
		`CHK("push lo", 8'h3c, u_aao_mem_model.ram[8'h40])
		`CHK("push hi", 8'h09, u_aao_mem_model.ram[8'h41])
		setup(8'h00, 4'h0);
		run(OP_POPAF, 3'h0, ADR, 8'h00);
		cr("stack", REG_STACK, 8'h40);
		cr("acc", REG_ACC, 8'h3c);
		cr("flags", REG_FLAG, 8'h09);
		results();
	end
endmodule // test_accumulator_alu_ops
